/* rtl/ewp_host.sv */
`timescale 1ns/1ps
`include "ewp_defs.svh"

// How it works
// - strobes come from flops only, held steady, no glitches on select lines
// - protect line held low during our reset and until reset releases
// - protect falls at once on our reset, even inside the 10 ms after the final data load
// - while locked each plain write is preceded by the three command bytes
// - successive bytes within one sequence start well inside 30 us
// - one data byte per sequence so page bits never change inside a page load
module ewp_host
    import ewp_pkg::*;
#(
    parameter logic [16:0] CMD_A0 = `EWP_CMD_A0,
    parameter logic [16:0] CMD_A1 = `EWP_CMD_A1,
    parameter logic [7:0] CMD_D0 = `EWP_CMD_D0,
    parameter logic [7:0] CMD_D1 = `EWP_CMD_D1,
    parameter logic [7:0] CMD_EN = `EWP_CMD_EN,
    parameter logic [7:0] CMD_DIS0 = `EWP_CMD_DIS0,
    parameter logic [7:0] CMD_DIS1 = `EWP_CMD_DIS1,
    parameter int PROG_HOLD_CYC = `EWP_PROG_HOLD_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire ewp_req_s req,
    output logic req_ready,
    output logic busy,
    output logic software_write_lock,
    output ewp_pins_s pins,
    output logic [16:0] addr,
    output logic [7:0] data_out,
    output logic data_oe_n
);
    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    localparam int CW = $clog2(PROG_HOLD_CYC + 1);

    ewp_state_e state, next_state;
    logic [CW-1:0] cnt, next_cnt;
    logic [2:0] idx, next_idx;
    logic [2:0] last, next_last;
    ewp_req_s cur, next_cur;
    logic lock, next_lock;
    logic arm, next_arm;
    logic [16:0] seq_a;
    logic [7:0] seq_d;

    // step table: disable is A0 D0, A1 D1, A0 DIS0, A0 D0, A1 D1, A0 DIS1
    always_comb begin
        seq_a = cur.addr;
        seq_d = cur.data;
        if (cur.op == EWP_OP_UNLOCK) begin
            unique case (idx)
                3'h0, 3'h3: begin
                    seq_a = CMD_A0;
                    seq_d = CMD_D0;
                end
                3'h1, 3'h4: begin
                    seq_a = CMD_A1;
                    seq_d = CMD_D1;
                end
                3'h2: begin
                    seq_a = CMD_A0;
                    seq_d = CMD_DIS0;
                end
                default: begin
                    seq_a = CMD_A0;
                    seq_d = CMD_DIS1;
                end
            endcase
        end else if (idx < last) begin
            unique case (idx)
                3'h0: begin
                    seq_a = CMD_A0;
                    seq_d = CMD_D0;
                end
                3'h1: begin
                    seq_a = CMD_A1;
                    seq_d = CMD_D1;
                end
                default: begin
                    seq_a = CMD_A0;
                    seq_d = CMD_EN;
                end
            endcase
        end
    end

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_idx = idx;
        next_last = last;
        next_cur = cur;
        next_lock = lock;
        next_arm = arm;
        unique case (state)
            EWP_IDLE: begin
                // requests wait until the protect line is released by reset
                if (req_valid) begin
                    next_cur = req;
                    next_idx = 3'h0;
                    next_cnt = '0;
                    next_state = EWP_SETUP;
                    // lock, or write while locked, gets prefix
                    if (req.op == EWP_OP_UNLOCK) begin
                        next_last = 3'h5;
                    end else if (req.op == EWP_OP_LOCK || lock) begin
                        next_last = 3'h3;
                    end else begin
                        next_last = 3'h0;
                    end
                    next_arm = (req.op == EWP_OP_LOCK);
                end
            end
            EWP_SETUP: begin
                // address settles before the strobe falls
                next_cnt = cnt + 1'b1;
                if (cnt == CW'(`EWP_SETUP_CYC - 1)) begin
                    next_cnt = '0;
                    next_state = EWP_STROBE;
                end
            end
            EWP_STROBE: begin
                // pulse far above the filter width
                next_cnt = cnt + 1'b1;
                if (cnt == CW'(`EWP_STROBE_CYC - 1)) begin
                    next_cnt = '0;
                    next_state = EWP_GAP;
                end
            end
            EWP_GAP: begin
                // data held one cycle past the rising edge
                // next byte follows at once, far inside 30 us
                if (idx == last) begin
                    next_state = EWP_HOLD;
                end else begin
                    next_idx = idx + 1'b1;
                    next_state = EWP_SETUP;
                end
            end
            EWP_HOLD: begin
                // wait out internal programming before anything else
                next_cnt = cnt + 1'b1;
                if (cnt == CW'(PROG_HOLD_CYC - 1)) begin
                    next_cnt = '0;
                    next_state = EWP_IDLE;
                    if (cur.op == EWP_OP_UNLOCK) begin
                        next_lock = 1'b0;
                    end else if (arm) begin
                        next_lock = 1'b1;
                    end
                end
            end
            default: next_state = EWP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= EWP_IDLE;
            cnt <= '0;
            idx <= 3'h0;
            last <= 3'h0;
            cur <= '0;
            lock <= 1'b0;
            arm <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            idx <= next_idx;
            last <= next_last;
            cur <= next_cur;
            lock <= next_lock;
            arm <= next_arm;
        end
    end

    // ----------------------------------------
    // registered pins
    // ----------------------------------------
    logic active;
    assign active = (state != EWP_IDLE);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pins.protect_hold_n <= 1'b0;
            pins.cs_n <= 1'b1;
            pins.oe_n <= 1'b1;
            pins.we_n <= 1'b1;
            addr <= '0;
            data_out <= '0;
            data_oe_n <= 1'b1;
            req_ready <= 1'b0;
            busy <= 1'b0;
            software_write_lock <= 1'b0;
        end else begin
            pins.protect_hold_n <= 1'b1;
            pins.oe_n <= 1'b1;
            pins.cs_n <= ~(next_state == EWP_STROBE);
            pins.we_n <= ~(next_state == EWP_STROBE);
            if (next_state == EWP_SETUP) begin
                addr <= (state == EWP_IDLE) ? ((req.op == EWP_OP_UNLOCK) ? CMD_A0 : addr)
                                             : addr;
            end
            if (state == EWP_SETUP) begin
                addr <= seq_a;
                data_out <= seq_d;
            end
            data_oe_n <= ~(next_state == EWP_SETUP || next_state == EWP_STROBE
                           || next_state == EWP_GAP);
            req_ready <= (next_state == EWP_IDLE);
            busy <= (next_state != EWP_IDLE) || active;
            software_write_lock <= next_lock;
        end
    end
endmodule

/* pkg/ewp_defs.svh */
`ifndef EWP_DEFS_SVH
`define EWP_DEFS_SVH

`define EWP_CLK_HZ 10000000
// timing figures in their own unit
`define EWP_GLITCH_NS 20
`define EWP_PROG_HOLD_MS 10
`define EWP_BYTE_LOAD_MAX_US 30
`define EWP_WE_PULSE_NS 250
// cycle counts derived from the clock
`define EWP_WE_PULSE_CYC ((`EWP_WE_PULSE_NS * 10 + 999) / 1000)
`define EWP_GLITCH_CYC ((`EWP_GLITCH_NS * 10 + 999) / 1000)
`define EWP_STROBE_CYC (`EWP_WE_PULSE_CYC + `EWP_GLITCH_CYC)
`define EWP_SETUP_CYC 2
`define EWP_PROG_HOLD_CYC ((`EWP_CLK_HZ / 1000) * `EWP_PROG_HOLD_MS)
`define EWP_BYTE_LOAD_MAX_CYC ((`EWP_BYTE_LOAD_MAX_US * 10))
// neutral command-byte defaults
`define EWP_CMD_A0 17'h05555
`define EWP_CMD_A1 17'h02AAA
`define EWP_CMD_D0 8'hAA
`define EWP_CMD_D1 8'h55
`define EWP_CMD_EN 8'hA0
`define EWP_CMD_DIS0 8'h80
`define EWP_CMD_DIS1 8'h20

`endif

/* pkg/ewp_pkg.sv */
package ewp_pkg;
    typedef enum logic [2:0] {
        EWP_IDLE = 3'b000,
        EWP_SETUP = 3'b001,
        EWP_STROBE = 3'b011,
        EWP_GAP = 3'b010,
        EWP_HOLD = 3'b110
    } ewp_state_e;

    typedef enum logic [1:0] {
        EWP_OP_WRITE = 2'h0,
        EWP_OP_LOCK = 2'h1,
        EWP_OP_UNLOCK = 2'h2
    } ewp_op_e;

    typedef struct packed {
        ewp_op_e op;
        logic [16:0] addr;
        logic [7:0] data;
    } ewp_req_s;

    typedef struct packed {
        logic cs_n;
        logic oe_n;
        logic we_n;
        logic protect_hold_n;
    } ewp_pins_s;
endpackage

/* tb/ewp_host_properties.sv */
`timescale 1ns/1ps
`include "ewp_defs.svh"
module ewp_host_properties
    import ewp_pkg::*;
#(
    parameter int PROG_HOLD_CYC = 20
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire ewp_req_s req,
    input wire logic req_ready,
    input wire logic busy,
    input wire logic software_write_lock,
    input wire ewp_pins_s pins,
    input wire logic [16:0] addr,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n
);
    // strobe-high cycles since the last strobe or idle; saturates so idle never wraps
    logic [19:0] idle_cnt;
    logic [19:0] next_idle_cnt;
    always_comb begin
        next_idle_cnt = (!pins.we_n || req_ready) ? 20'h00000 : idle_cnt + {19'h0, ~&idle_cnt};
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) idle_cnt <= 20'h00000;
        else idle_cnt <= next_idle_cnt;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    strobe_pair_a:
    assert property (pins.oe_n && pins.cs_n == pins.we_n) else $error("strobes apart");
    strobe_wide_a:
    assert property ($fell(pins.we_n) |-> !pins.we_n [*4] ##1 pins.we_n)
        else $error("strobe width wrong");
    protect_held_a:
    assert property ($past(pins.protect_hold_n) |-> pins.protect_hold_n)
        else $error("protect dropped");
    prog_hold_a:
    assert property ($rose(req_ready) && $past(busy) |-> idle_cnt >= PROG_HOLD_CYC)
        else $error("hold too short");
    page_stable_a:
    assert property ($fell(pins.we_n) |=> ($stable(addr) && $stable(data_out) && !data_oe_n) [*4])
        else $error("bus moved in strobe");
    byte_gap_a:
    assert property ($fell(pins.we_n) |-> idle_cnt < 20'h0012C) else $error("byte gap too long");
    prefix_first_a:
    assert property (req_valid && req_ready && (req.op != EWP_OP_WRITE || software_write_lock)
        |-> ##[1:4] !pins.we_n && addr == `EWP_CMD_A0 && data_out == `EWP_CMD_D0)
        else $error("prefix missing");
endmodule
bind ewp_host ewp_host_properties #(.PROG_HOLD_CYC(PROG_HOLD_CYC)) u_props (
    .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .busy(busy), .software_write_lock(software_write_lock), .pins(pins), .addr(addr),
    .data_out(data_out), .data_oe_n(data_oe_n));

/* tb/ewp_eeprom_model.sv */
`timescale 1ns/1ps
`include "ewp_defs.svh"
module ewp_eeprom_model
    import ewp_pkg::*;
(
    input wire ewp_pins_s pins,
    input wire logic [16:0] addr,
    input wire logic [7:0] data_out
);
    logic [7:0] mem [logic [16:0]];
    logic locked = 1'b0;
    logic dis = 1'b0;
    logic [16:0] a;
    logic [7:0] d;
    int n = 0;
    realtime t_fall = 0;
    wire stb_n = pins.cs_n | pins.we_n;
    function automatic logic [7:0] rd(input logic [16:0] ad);
        return mem.exists(ad) ? mem[ad] : 8'hFF;
    endfunction
    // pending sequence is lost when protect drops
    always @(negedge pins.protect_hold_n) n = 0;
    always @(negedge stb_n) begin
        t_fall = $realtime;
        a = addr;
    end
    always @(posedge stb_n) begin
        d = data_out;
        if (pins.protect_hold_n && $realtime - t_fall > 20.0) begin
            if (n == 3 && !dis) begin
                mem[a] = d;
                locked = 1'b1;
                n = 0;
            end else if (n == 0 && a == `EWP_CMD_A0 && d == `EWP_CMD_D0
                || (n == 1 || n == 4) && a == `EWP_CMD_A1 && d == `EWP_CMD_D1
                || n == 3 && a == `EWP_CMD_A0 && d == `EWP_CMD_D0) begin
                n++;
            end else if (n == 2 && a == `EWP_CMD_A0 && (d == `EWP_CMD_EN || d == `EWP_CMD_DIS0)) begin
                dis = (d == `EWP_CMD_DIS0);
                n = 3;
            end else if (n == 5 && a == `EWP_CMD_A0 && d == `EWP_CMD_DIS1) begin
                locked = 1'b0;
                n = 0;
            end else begin
                n = 0;
                if (!locked) mem[a] = d;
            end
        end
    end
endmodule

/* tb/eeprom_write_protection_bench.sv */
`timescale 1ns/1ps
module eeprom_write_protection_bench;
    import ewp_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    ewp_req_s req = '0;
    logic req_ready, busy, software_write_lock, data_oe_n;
    ewp_pins_s pins;
    logic [16:0] addr;
    logic [7:0] data_out;
    int n_errors = 0;
    int check_count = 0;
    always #50 core_clk = ~core_clk;
    ewp_host #(.PROG_HOLD_CYC(20)) u_dut (.core_clk(core_clk), .rst(rst),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .busy(busy),
        .software_write_lock(software_write_lock), .pins(pins), .addr(addr),
        .data_out(data_out), .data_oe_n(data_oe_n));
    ewp_eeprom_model u_mem (.pins(pins), .addr(addr), .data_out(data_out));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // entered at a falling edge with the host idle
    task automatic do_req(input ewp_op_e op, input logic [16:0] a, input logic [7:0] d);
        req_valid = 1'b1;
        req = '{op, a, d};
        @(negedge core_clk);
        req_valid = 1'b0;
        chk("busy", busy, 1'b1);
        for (int k = 0; k < 200 && req_ready !== 1'b1; k++) @(negedge core_clk);
        chk("ready", req_ready, 1'b1);
    endtask
    task automatic t_plain();
        do_req(EWP_OP_WRITE, 17'h00123, 8'h3C);
        chk("plain byte", u_mem.rd(17'h00123), 8'h3C);
        chk("lock flag", software_write_lock, 1'b0);
        $display("test plain done");
    endtask
    task automatic t_lock();
        do_req(EWP_OP_LOCK, 17'h1FFFF, 8'hC3);
        chk("lock byte", u_mem.rd(17'h1FFFF), 8'hC3);
        chk("device lock", u_mem.locked, 1'b1);
        chk("lock flag", software_write_lock, 1'b1);
        do_req(EWP_OP_WRITE, 17'h00123, 8'hA5);
        chk("locked byte", u_mem.rd(17'h00123), 8'hA5);
        $display("test lock done");
    endtask
    task automatic t_unlock();
        do_req(EWP_OP_UNLOCK, 17'h00777, 8'hEE);
        chk("device lock", u_mem.locked, 1'b0);
        chk("lock flag", software_write_lock, 1'b0);
        chk("no byte", u_mem.rd(17'h00777), 8'hFF);
        do_req(EWP_OP_WRITE, 17'h00124, 8'h81);
        chk("open byte", u_mem.rd(17'h00124), 8'h81);
        $display("test unlock done");
    endtask
    task automatic t_reset();
        rst = 1'b1;
        @(negedge core_clk);
        chk("protect low", pins.protect_hold_n, 1'b0);
        rst = 1'b0;
        repeat (2) @(negedge core_clk);
        chk("protect high", pins.protect_hold_n, 1'b1);
        chk("ready after reset", req_ready, 1'b1);
        chk("idle after reset", busy, 1'b0);
        chk("lock after reset", software_write_lock, 1'b0);
        $display("test reset done");
    endtask
    initial begin
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        repeat (2) @(negedge core_clk);
        t_plain();
        t_lock();
        t_unlock();
        t_reset();
        end_sim();
    end
    initial begin
        #(5000 * 100);
        n_errors++;
        end_sim();
    end
endmodule
